// ==== rtl/phbu_flag.sv ====
// per-flag decision: buffer copy update and table search need
`timescale 1ns/1ps
module phbu_flag #(
  parameter bit ASSUME_SET_ON_HIT = 1'b0
) (
  input wire logic want,
  input wire logic hit,
  input wire logic cached,
  output logic search,
  output logic tlb_set
);
  logic known;

  // on a hit the cached copy stands for the table; referenced may be assumed set
  assign known = hit && (ASSUME_SET_ON_HIT || cached);
  assign search = want && !known;
  assign tlb_set = want && hit && !cached;
endmodule : phbu_flag

// ==== rtl/phbu_pkg.sv ====
// types shared by the page history bit updater
package phbu_pkg;
  // access kinds as seen by history recording
  typedef enum logic [3:0] {
    PHBU_FETCH,
    PHBU_LOAD,
    PHBU_EXT_IN,
    PHBU_TOUCH,
    PHBU_TOUCH_ST,
    PHBU_CACHE_FLUSH,
    PHBU_STORE,
    PHBU_EXT_OUT,
    PHBU_CACHE_ZERO,
    PHBU_CACHE_ALLOC,
    PHBU_CACHE_INVAL
  } phbu_kind_t;
endpackage : phbu_pkg

// ==== rtl/phbu_regs.svh ====
// constants for the page history bit updater
// Summary of operation
// - with both cached flags set, no table search for read or write.
// - updates may use buffer copies; on hit referenced counts as set.
// - cache touch ops may set referenced, never changed.
// - table writes use real addresses, translation off.
// - every page reference sets referenced, now or once known to succeed.
// - hardware never clears referenced.
// - referenced may be set for accesses not logically needed.
// - successful store hit: set cached changed if clear and search table.
// - changed set only for permitted, certain stores; exempt exceptions excepted.
// - changed also by permitted no-store conditional, zero-length store, allocate, invalidate.
// - table updates use attributes unguarded, cacheable, coherent.
// - scenarios evaluated in fixed priority, highest match wins.
// - control input and load-like cache ops are loads; others stores.
// - no-execute sets nothing; protection or out-of-order fetch/load never changed.
// - out-of-order store with no other precise exception may set both.
// - other out-of-order stores may set referenced only.
// - zero-length load referenced only; zero-length or no-store conditional both.
// - in-order fetch, load or control input sets referenced only.
// - both clear: read searches to set referenced, write sets both; here a read that hits only sets the cached referenced copy, with no search.
// - only referenced set: read nothing, write searches to set changed.
// - in-order store, control output, block zero, allocate set both.
`ifndef PHBU_REGS_SVH
`define PHBU_REGS_SVH
// bit positions inside the second entry word, bit 0 = lsb
`define PHBU_PTE_REF_BIT 8
`define PHBU_PTE_CHG_BIT 7
// attributes used for every history update
`define PHBU_UPDATE_CCA 4'h2
`define PHBU_CCA_W 4
`endif

// ==== rtl/phbu_scenario.sv ====
// priority scenario model deciding which history flags an access sets
`timescale 1ns/1ps
module phbu_scenario (
  input wire phbu_pkg::phbu_kind_t kind,
  input wire logic translated,
  input wire logic noexec_viol,
  input wire logic prot_viol,
  input wire logic out_of_order,
  input wire logic no_other_precise,
  input wire logic zero_length,
  input wire logic no_store,
  input wire logic exc_pending,
  input wire logic exc_exempt,
  output logic want_ref,
  output logic want_chg
);
  logic is_fetch;
  logic load_like;
  logic store_like;
  logic chg_kind;

  // classing of control and cache operations
  assign is_fetch = (kind == phbu_pkg::PHBU_FETCH);
  assign load_like = (kind == phbu_pkg::PHBU_LOAD) || (kind == phbu_pkg::PHBU_EXT_IN) ||
                     (kind == phbu_pkg::PHBU_TOUCH) || (kind == phbu_pkg::PHBU_TOUCH_ST);
  assign store_like = !is_fetch && !load_like;
  // flush-style ops count as stores but never dirty the page; touches never do either
  assign chg_kind = store_like && (kind != phbu_pkg::PHBU_CACHE_FLUSH);

  // first matching row wins
  always_comb begin
    want_ref = 1'b0;
    want_chg = 1'b0;
    if (!translated) begin
      want_ref = 1'b0;
    end else if (noexec_viol) begin
      want_ref = 1'b0;
    end else if (prot_viol) begin
      want_ref = 1'b1;
    end else if (out_of_order && !store_like) begin
      want_ref = 1'b1;
    end else if (out_of_order) begin
      want_ref = 1'b1;
      want_chg = chg_kind && no_other_precise;
    end else if (zero_length && !store_like) begin
      want_ref = 1'b1;
    end else if (zero_length || no_store) begin
      want_ref = 1'b1;
      want_chg = chg_kind;
    end else if (!store_like) begin
      want_ref = 1'b1;
    end else begin
      want_ref = 1'b1;
      // allocate and invalidate dirty the page even under a pending exception
      want_chg = chg_kind && ((kind == phbu_pkg::PHBU_CACHE_ALLOC) ||
                 (kind == phbu_pkg::PHBU_CACHE_INVAL) || !exc_pending || exc_exempt);
    end
  end
endmodule : phbu_scenario

// ==== rtl/phbu_top.sv ====
// page history bit updater: scenario model, buffer copy update, table write-back
`timescale 1ns/1ps
`include "phbu_regs.svh"
module phbu_top #(
  parameter int ADDR_W = 32,
  parameter int DATA_W = 32
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic acc_valid,
  output logic acc_ready,
  input wire phbu_pkg::phbu_kind_t acc_kind,
  input wire logic acc_translated,
  input wire logic acc_noexec_viol,
  input wire logic acc_prot_viol,
  input wire logic acc_out_of_order,
  input wire logic acc_no_other_precise,
  input wire logic acc_zero_length,
  input wire logic acc_no_store,
  input wire logic acc_exc_pending,
  input wire logic acc_exc_exempt,
  input wire logic tlb_hit,
  input wire logic tlb_ref,
  input wire logic tlb_chg,
  input wire logic [ADDR_W-1:0] pte_addr,
  output logic tlb_set_ref,
  output logic tlb_set_chg,
  output logic mem_req,
  output logic mem_write,
  output logic mem_lock,
  output logic mem_real,
  output logic [`PHBU_CCA_W-1:0] mem_cache_control_attributes,
  output logic [ADDR_W-1:0] mem_addr,
  output logic [DATA_W-1:0] mem_wdata,
  input wire logic mem_ack,
  input wire logic [DATA_W-1:0] mem_rdata,
  output logic upd_busy
);
  // ****************************************
  // decision logic
  // ****************************************
  typedef enum logic [1:0] {
    PHBU_IDLE,
    PHBU_READ,
    PHBU_WRITE
  } phbu_state_t;

  phbu_state_t state;
  logic want_ref;
  logic want_chg;
  logic search_ref;
  logic search_chg;
  logic set_ref_tlb;
  logic set_chg_tlb;
  logic take;
  logic start;
  logic pend_ref;
  logic pend_chg;
  logic [DATA_W-1:0] merged;

  assign acc_ready = (state == PHBU_IDLE);
  assign take = acc_valid && acc_ready;
  assign start = take && (search_ref || search_chg);

  // scenario model in priority order
  phbu_scenario u_scenario (
    .kind(acc_kind),
    .translated(acc_translated),
    .noexec_viol(acc_noexec_viol),
    .prot_viol(acc_prot_viol),
    .out_of_order(acc_out_of_order),
    .no_other_precise(acc_no_other_precise),
    .zero_length(acc_zero_length),
    .no_store(acc_no_store),
    .exc_pending(acc_exc_pending),
    .exc_exempt(acc_exc_exempt),
    .want_ref(want_ref),
    .want_chg(want_chg)
  );

  // referenced is taken as already set whenever the buffer hits
  phbu_flag #(
    .ASSUME_SET_ON_HIT(1'b1)
  ) u_flag_ref (
    .want(want_ref),
    .hit(tlb_hit),
    .cached(tlb_ref),
    .search(search_ref),
    .tlb_set(set_ref_tlb)
  );

  phbu_flag #(
    .ASSUME_SET_ON_HIT(1'b0)
  ) u_flag_chg (
    .want(want_chg),
    .hit(tlb_hit),
    .cached(tlb_chg),
    .search(search_chg),
    .tlb_set(set_chg_tlb)
  );

  // ****************************************
  // buffer copy update
  // ****************************************

  // one-cycle pulses, only ever setting the cached copies
  always_ff @(posedge clk) begin
    if (rst) begin
      tlb_set_ref <= 1'b0;
      tlb_set_chg <= 1'b0;
    end else begin
      tlb_set_ref <= take && set_ref_tlb;
      tlb_set_chg <= take && set_chg_tlb;
    end
  end

  // ****************************************
  // table read-modify-write
  // ****************************************

  // bits to or into the entry; clearing is never possible
  always_comb begin
    merged = mem_rdata;
    merged[`PHBU_PTE_REF_BIT] = mem_rdata[`PHBU_PTE_REF_BIT] | pend_ref | pend_chg;
    merged[`PHBU_PTE_CHG_BIT] = mem_rdata[`PHBU_PTE_CHG_BIT] | pend_chg;
  end

  // pending flag bits of the running update
  always_ff @(posedge clk) begin
    if (rst) begin
      pend_ref <= 1'b0;
      pend_chg <= 1'b0;
    end else if (start) begin
      pend_ref <= want_ref;
      pend_chg <= want_chg;
    end
  end

  // sequencer; lock spans read and write so a neighbour's update is not lost
  always_ff @(posedge clk) begin
    if (rst) begin
      state <= PHBU_IDLE;
      mem_req <= 1'b0;
      mem_write <= 1'b0;
      mem_lock <= 1'b0;
      mem_addr <= '0;
      mem_wdata <= '0;
    end else begin
      case (state)
        PHBU_IDLE: begin
          if (start) begin
            state <= PHBU_READ;
            mem_req <= 1'b1;
            mem_write <= 1'b0;
            mem_lock <= 1'b1;
            mem_addr <= pte_addr;
          end
        end
        PHBU_READ: begin
          if (mem_ack) begin
            state <= PHBU_WRITE;
            mem_write <= 1'b1;
            mem_wdata <= merged;
          end
        end
        PHBU_WRITE: begin
          if (mem_ack) begin
            state <= PHBU_IDLE;
            mem_req <= 1'b0;
            mem_write <= 1'b0;
            mem_lock <= 1'b0;
          end
        end
        default: begin
          state <= PHBU_IDLE;
          mem_req <= 1'b0;
          mem_write <= 1'b0;
          mem_lock <= 1'b0;
        end
      endcase
    end
  end

  // updates always go out physical with fixed attributes
  assign mem_real = 1'b1;
  assign mem_cache_control_attributes = `PHBU_UPDATE_CCA;
  assign upd_busy = (state != PHBU_IDLE);

  // ****************************************
  // checks
  // ****************************************
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);

  // an access that needs the table
  sequence s_started;
    take && (search_ref || search_chg);
  endsequence

  // read half of the locked update answered
  sequence s_read_ack;
    mem_req && mem_lock && !mem_write && mem_ack;
  endsequence

  // write half answered; the entry is final from here on
  sequence s_write_ack;
    mem_req && mem_lock && mem_write && mem_ack;
  endsequence

  // ****************************************
  // decision checks
  // ****************************************

  // cached flags decide whether the table is touched at all
  both_set_idle_a: assert property ((take && tlb_hit && tlb_ref && tlb_chg) |=> !mem_req && !tlb_set_chg)
    else $error("search started though both cached flags set");

  hit_ref_nosearch_a: assert property ((take && tlb_hit && !want_chg) |=> !mem_req)
    else $error("search started on hit without changed update");

  touch_no_chg_a: assert property ((take && (acc_kind == phbu_pkg::PHBU_TOUCH ||
      acc_kind == phbu_pkg::PHBU_TOUCH_ST)) |=> !tlb_set_chg && !(mem_req && pend_chg))
    else $error("touch set changed flag");

  // scenario rows, from protection and no-execute down to in-order accesses
  prot_no_chg_a: assert property ((take && acc_prot_viol) |-> !want_chg)
    else $error("protection violation set changed");

  noexec_nothing_a: assert property ((take && acc_translated && acc_noexec_viol) |=>
      !tlb_set_ref && !tlb_set_chg && !mem_req)
    else $error("no-execute violation set a flag");

  load_ref_only_a: assert property ((take && acc_translated && !acc_noexec_viol && !acc_out_of_order &&
      (acc_kind == phbu_pkg::PHBU_LOAD || acc_kind == phbu_pkg::PHBU_FETCH ||
      acc_kind == phbu_pkg::PHBU_EXT_IN)) |-> want_ref && !want_chg)
    else $error("in-order load or fetch flags wrong");

  store_both_a: assert property ((take && acc_translated && !acc_noexec_viol && !acc_prot_viol &&
      !acc_out_of_order && !acc_exc_pending && (acc_kind == phbu_pkg::PHBU_STORE ||
      acc_kind == phbu_pkg::PHBU_EXT_OUT || acc_kind == phbu_pkg::PHBU_CACHE_ZERO ||
      acc_kind == phbu_pkg::PHBU_CACHE_ALLOC)) |-> want_ref && want_chg)
    else $error("in-order store did not set both");

  flush_no_chg_a: assert property ((take && acc_kind == phbu_pkg::PHBU_CACHE_FLUSH) |-> !want_chg)
    else $error("flush set changed flag");

  // out-of-order cases with another precise exception, and plain stores under a non-exempt pending exception, may mark use but must not dirty the page
  ooo_store_chg_a: assert property ((take && acc_translated && !acc_noexec_viol && !acc_prot_viol &&
      acc_out_of_order && !acc_no_other_precise) |-> want_ref && !want_chg)
    else $error("out-of-order store set changed");

  exc_blocks_chg_a: assert property ((take && acc_kind == phbu_pkg::PHBU_STORE && acc_exc_pending &&
      !acc_exc_exempt && !acc_out_of_order && !acc_zero_length && !acc_no_store) |-> !want_chg)
    else $error("store under pending exception set changed");

  zero_store_both_a: assert property ((take && acc_translated && !acc_noexec_viol && !acc_prot_viol &&
      !acc_out_of_order && acc_zero_length && acc_kind == phbu_pkg::PHBU_STORE) |-> want_ref && want_chg)
    else $error("zero-length store flags wrong");

  // ****************************************
  // buffer and table update checks
  // ****************************************

  // buffer copies only ever get set, never cleared
  store_hit_clear_a: assert property ((take && tlb_hit && !tlb_chg && want_chg) |=>
      tlb_set_chg && mem_req && mem_lock && !mem_write)
    else $error("store hit did not set changed and search");

  set_chg_pulse_a: assert property (tlb_set_chg |=> !tlb_set_chg)
    else $error("changed copy pulse longer than one cycle");

  ref_tlb_set_a: assert property ((take && tlb_hit && !tlb_ref && want_ref) |=> tlb_set_ref)
    else $error("cached referenced copy not set");

  miss_search_a: assert property ((take && !tlb_hit && want_ref) |=> mem_req && mem_addr == $past(pte_addr))
    else $error("miss did not start a table search");

  // the table word goes out physical, locked around read and write
  real_cca_a: assert property (mem_req |-> mem_real &&
      mem_cache_control_attributes == `PHBU_UPDATE_CCA)
    else $error("update issued with wrong attributes");

  ref_never_cleared_a: assert property ((mem_req && mem_write) |->
      mem_wdata[`PHBU_PTE_REF_BIT] && (mem_wdata[`PHBU_PTE_CHG_BIT] || !pend_chg))
    else $error("write-back lacks history bits");

  locked_rmw_a: assert property (s_started |=> ##[0:1000] (mem_lock && mem_write))
    else $error("read not followed by locked write");

  lock_held_a: assert property ((mem_req && !mem_write) |-> mem_lock)
    else $error("read issued without lock");

  // no other master may slip between the read and the write of one entry
  rmw_write_a: assert property (s_read_ack |=> mem_req && mem_lock && mem_write)
    else $error("read answer not followed by locked write");

  rmw_release_a: assert property (s_write_ack |=> !mem_req && !mem_lock && acc_ready)
    else $error("lock kept after write answer");

  // a partner may stall; the request must not move under it
  req_stable_a: assert property ((mem_req && !mem_ack) |=>
      mem_req && $stable(mem_addr) && $stable(mem_write) && $stable(mem_wdata))
    else $error("update request changed before its answer");
endmodule : phbu_top

// ==== testbench/phbu_mem_model.sv ====
// page table memory partner answering locked read-modify-write updates
`timescale 1ns/1ps
module phbu_mem_model (
  input wire logic clk,
  input wire logic rst,
  input wire logic mem_req,
  input wire logic mem_write,
  input wire logic [31:0] mem_addr,
  input wire logic [31:0] mem_wdata,
  input wire logic [1:0] lat,
  output logic mem_ack,
  output logic [31:0] mem_rdata
);
  // ****
  // storage and answer timing
  // ****
  logic [31:0] mem [0:3];
  logic [31:0] last;
  logic [1:0] cnt;
  // one ack per request after lat+1 cycles, never one without a request
  always @(posedge clk) begin
    if (rst) begin
      mem_ack <= 1'b0;
      cnt <= 2'h0;
      last <= 32'h0;
    end else if (mem_req && !mem_ack && cnt == lat) begin
      mem_ack <= 1'b1;
      cnt <= 2'h0;
      if (mem_write) mem[mem_addr[3:2]] <= mem_wdata;
      else last <= mem[mem_addr[3:2]];
    end else begin
      mem_ack <= 1'b0;
      if (mem_req && !mem_ack) cnt <= cnt + 2'h1;
    end
  end
  // released data lines show the inverse, so stale data cannot pass
  assign mem_rdata = (mem_ack && !mem_write) ? last : ~last;
endmodule : phbu_mem_model

// ==== testbench/tb_top.sv ====
// self-checking bench for the page history bit updater
`timescale 1ns/1ps
module tb_top;
  // ****
  // stimulus, design and partner
  // ****
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic acc_valid = 1'b0;
  phbu_pkg::phbu_kind_t acc_kind = phbu_pkg::PHBU_FETCH;
  logic [11:0] qual = 12'h000; // qualifiers, hit, cached ref, cached chg
  logic [31:0] pte_addr = 32'h0;
  logic [31:0] cur_addr = 32'h0;
  logic [1:0] lat = 2'h0;
  logic acc_ready, tlb_set_ref, tlb_set_chg, mem_req, mem_write, mem_lock, mem_real, mem_ack, upd_busy;
  logic [3:0] mem_attr;
  logic [31:0] mem_addr, mem_wdata, mem_rdata;
  int error_cnt = 0;
  int num_checks = 0;
  // 20 ns half period for 25 MHz
  always #20 clk = ~clk;
  phbu_top i_phbu_top (
    .clk(clk), .rst(rst), .acc_valid(acc_valid), .acc_ready(acc_ready), .acc_kind(acc_kind),
    .acc_translated(qual[11]), .acc_noexec_viol(qual[10]), .acc_prot_viol(qual[9]),
    .acc_out_of_order(qual[8]), .acc_no_other_precise(qual[7]), .acc_zero_length(qual[6]),
    .acc_no_store(qual[5]), .acc_exc_pending(qual[4]), .acc_exc_exempt(qual[3]),
    .tlb_hit(qual[2]), .tlb_ref(qual[1]), .tlb_chg(qual[0]), .pte_addr(pte_addr),
    .tlb_set_ref(tlb_set_ref), .tlb_set_chg(tlb_set_chg), .mem_req(mem_req), .mem_write(mem_write),
    .mem_lock(mem_lock), .mem_real(mem_real), .mem_cache_control_attributes(mem_attr),
    .mem_addr(mem_addr), .mem_wdata(mem_wdata), .mem_ack(mem_ack), .mem_rdata(mem_rdata),
    .upd_busy(upd_busy)
  );
  phbu_mem_model i_phbu_mem_model (
    .clk(clk), .rst(rst), .mem_req(mem_req), .mem_write(mem_write), .mem_addr(mem_addr),
    .mem_wdata(mem_wdata), .lat(lat), .mem_ack(mem_ack), .mem_rdata(mem_rdata)
  );
  // rows: kind, qual value, expected {set chg, search, table ref, table chg}
  // last row: hit with the cached referenced copy clear
  logic [19:0] rows [29] = '{
    20'h08006, 20'h18006, 20'h28006, 20'h68007, 20'h78007, 20'h88007, 20'h98007,
    20'ha8007, 20'h38006, 20'h48006, 20'h58006, 20'h6c000, 20'h6a006, 20'h6a206,
    20'h19006, 20'h69807, 20'h69006, 20'h18406, 20'h68407, 20'h68207, 20'h68106,
    20'h68187, 20'h60000, 20'h18060, 20'h6806f, 20'h68070, 20'h18070, 20'h9816f, 20'h18040
  };
  // ****
  // shared tasks
  // ****
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic close_out();
    $display("checks %0d mismatches %0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : close_out
  task automatic timeout();
    error_cnt++;
    $display("wait limit reached at %0t", $time);
    close_out();
  endtask : timeout
  // holds the access until the edge that takes it, returns in the answer cycle
  task automatic drive(input logic [19:0] r, input logic [31:0] a);
    int n;
    n = 0;
    @(posedge clk);
    acc_valid <= 1'b1;
    acc_kind <= phbu_pkg::phbu_kind_t'(r[19:16]);
    qual <= r[15:4];
    pte_addr <= a;
    do begin
      @(posedge clk);
      n++;
    end while (acc_ready !== 1'b1 && n < 60);
    if (acc_ready !== 1'b1) timeout();
    cur_addr = a;
    acc_valid <= 1'b0;
    #1;
  endtask : drive
  task automatic idle();
    int n;
    n = 0;
    while (acc_ready !== 1'b1 && n < 60) begin
      @(posedge clk);
      #1;
      n++;
    end
    if (acc_ready !== 1'b1) timeout();
  endtask : idle
  // table word starts with changed mirroring the cached changed flag and referenced set on a hit or an odd row
  task automatic run_row(input logic [19:0] r, input int k);
    logic [31:0] pre;
    pre = 32'h1234_5600 | {23'h0, k[0] | r[6], r[4], 7'h0};
    i_phbu_mem_model.mem[k[1:0]] = pre;
    lat = 2'(k % 3);
    drive(r, 32'h0000_2000 + {28'h0, k[1:0], 2'h0});
    if (r[6]) begin
      check(tlb_set_chg, r[3]);
      check(tlb_set_ref, !r[5]);
    end
    check(mem_req, r[2]);
    check(upd_busy, r[2]);
    if (r[2]) check(mem_write, 0);
    idle();
    repeat (2) @(posedge clk);
    #1;
    check(i_phbu_mem_model.mem[k[1:0]], pre | {23'h0, r[1], r[0], 7'h0});
    $display("row %0d done", k); // above also
  endtask : run_row
  // every update request is a locked physical access to the entry word
  always @(posedge clk) begin
    if (!rst && mem_req === 1'b1) begin
      check(mem_real, 1);
      check(mem_attr, 4'h2);
      check(mem_lock, 1);
      check(mem_addr, cur_addr);
    end
  end
  // ****
  // scenarios
  // ****
  initial begin
    repeat (15) @(posedge clk);
    #1;
    check(acc_ready, 1);
    check(mem_req, 0);
    check(mem_real, 1);
    check(mem_attr, 4'h2);
    @(posedge clk);
    rst <= 1'b0;
    $display("reset test done");
    for (int k = 0; k < 29; k++) run_row(rows[k], k);
    // second access held while an update runs is refused until the first ends
    i_phbu_mem_model.mem[0] = 32'h0;
    i_phbu_mem_model.mem[1] = 32'h0;
    lat = 2'h3;
    drive(20'h68007, 32'h0000_2000);
    drive(20'h18006, 32'h0000_2004);
    check(i_phbu_mem_model.mem[0], 32'h180);
    idle();
    repeat (2) @(posedge clk);
    #1;
    check(i_phbu_mem_model.mem[1], 32'h100);
    $display("held access test done");
    // reset in mid update must drop the locked request
    drive(20'h68007, 32'h0000_2008);
    @(posedge clk);
    rst <= 1'b1;
    repeat (2) @(posedge clk);
    #1;
    check(mem_req, 0);
    check(mem_lock, 0);
    check(upd_busy, 0);
    check(acc_ready, 1);
    @(posedge clk);
    rst <= 1'b0;
    run_row(rows[3], 6);
    $display("mid reset test done");
    close_out();
  end
endmodule : tb_top
